/* File: bench/test_usb_dual_controller_host_bus_port.sv */
`timescale 1ns/10ps
`default_nettype none
module test_usb_dual_controller_host_bus_port
    import ubp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n, cs_n, kind, half, tb_rd_n, tb_wr_n, sel, host_side_dma_request, device_side_dma_request, data_oe;
    logic [15:0] tb_data, data_out;
    logic [3:0] end_after;
    logic dma_go;
    logic p_ack_n, p_wr_n, p_eot;
    logic [15:0] p_data;
    logic [3:0] p_words;
    int error_cnt = 0;
    int checks_done = 0;

    // Clock at 40 MHz.
    always #12.5 clk = ~clk;

    // Design under test; write strobe and data merge bus master and DMA master, read strobe comes from the bus master only.
    ubp_host_bus_port #(.DATA_W(16), .FIFO_WORDS(64)) uut (
        .CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .PORT_KIND_SELECT(kind),
        .CONTROLLER_HALF_SELECT(half), .RD_N(tb_rd_n), .WR_N(tb_wr_n & p_wr_n),
        .DATA_IN(p_ack_n ? tb_data : p_data), .DATA_OUT(data_out), .DATA_OE(data_oe),
        .HOST_SIDE_DMA_REQUEST(host_side_dma_request), .HOST_SIDE_DMA_ACK_N(sel | p_ack_n),
        .DEVICE_SIDE_DMA_REQUEST(device_side_dma_request), .DEVICE_SIDE_DMA_ACK_N(~sel | p_ack_n),
        .TRANSFER_END_INPUT(p_eot));

    // Far-side DMA controller.
    ubp_dma_master_model dma (
        .clk(clk), .req((sel ? device_side_dma_request : host_side_dma_request) & dma_go), .end_after(end_after), .ack_n(p_ack_n),
        .wr_n(p_wr_n), .data(p_data), .transfer_end_input(p_eot), .words(p_words));

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        $display("Checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One strobe held low then high for eight cycles each, starting 2 ns after an edge.
    task automatic bus(input logic [1:0] a, input logic wr, input logic [15:0] d,
                       output logic [15:0] q, output logic oe);
        cs_n = 1'b0;
        {half, kind} = a;
        tb_data = d;
        tb_wr_n = ~wr;
        tb_rd_n = wr;
        repeat (8) @(posedge clk);
        #2;
        q = data_out;
        oe = data_oe;
        tb_wr_n = 1'b1;
        tb_rd_n = 1'b1;
        cs_n = 1'b1;
        tb_data = ~tb_data;
        repeat (8) @(posedge clk);
        #2;
    endtask

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic oe;
        bus(a, 1'b1, d, q, oe);
    endtask

    task automatic rd(input logic [1:0] a, input logic [15:0] exp, input string nm);
        logic [15:0] q;
        logic oe;
        bus(a, 1'b0, 16'h0000, q, oe);
        chk(nm, exp, q);
        chk("read drive enable", 16'h0001, {15'h0000, oe});
    endtask

    // Command phase: index in the low byte, upper byte zero.
    task automatic cmd(input logic dev, input logic [7:0] idx);
        wr(dev ? UBP_PORT_DC_CMD : UBP_PORT_HC_CMD, {8'h00, idx});
    endtask

    task automatic wait_req(input logic dev, input logic exp, input string nm);
        for (int i = 0; i < 60; i++) begin
            if ((dev ? device_side_dma_request : host_side_dma_request) === exp) begin
                return;
            end
            @(posedge clk);
            #2;
        end
        checks_done++;
        error_cnt++;
        $display("Error %s expected %h seen timeout", nm, exp);
        report_and_stop();
    endtask

    task automatic wait_idle;
        for (int i = 0; i < 40 && p_ack_n !== 1'b1; i++) begin
            @(posedge clk);
        end
        #2;
        if (p_ack_n !== 1'b1) begin
            checks_done++;
            error_cnt++;
            $display("Error dma idle expected 1 seen %b", p_ack_n);
            report_and_stop();
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] q;
        logic oe;
        rst_n = 1'b0;
        cs_n = 1'b1;
        kind = 1'b0;
        half = 1'b0;
        tb_rd_n = 1'b1;
        tb_wr_n = 1'b1;
        tb_data = 16'h0000;
        sel = 1'b0;
        end_after = 4'h0;
        dma_go = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        rst_n = 1'b1;
        repeat (6) @(posedge clk);
        #2;
        cmd(1'b0, UBP_IDX_DMA_SETUP);
        rd(UBP_PORT_HC_DATA, UBP_DMA_SETUP_RST, "dma_setup reset");
        cmd(1'b0, UBP_IDX_BYTE_COUNT);
        rd(UBP_PORT_HC_DATA, UBP_BYTE_COUNT_RST, "byte count reset");
        cmd(1'b0, UBP_IDX_CHIP_ID);
        rd(UBP_PORT_HC_DATA, UBP_CHIP_ID_VALUE, "chip identity");
        cmd(1'b0, UBP_IDX_CHIP_ID | 8'h80);
        wr(UBP_PORT_HC_DATA, 16'h1234);
        cmd(1'b0, UBP_IDX_CHIP_ID);
        rd(UBP_PORT_HC_DATA, UBP_CHIP_ID_VALUE, "chip identity kept");
        bus(UBP_PORT_HC_CMD, 1'b0, 16'h0000, q, oe);
        chk("command port drive", 16'h0000, {15'h0000, oe});
        cmd(1'b0, UBP_IDX_BYTE_COUNT | 8'h80);
        wr(UBP_PORT_HC_DATA, 16'h0006);
        cmd(1'b0, UBP_IDX_BYTE_COUNT);
        rd(UBP_PORT_HC_DATA, 16'h0006, "byte count");
        cmd(1'b0, UBP_IDX_WIDE_SCRATCH | 8'h80);
        wr(UBP_PORT_HC_DATA, 16'hbeef);
        wr(UBP_PORT_HC_DATA, 16'h1357);
        cmd(1'b1, UBP_IDX_DC_SETUP | 8'h80);
        wr(UBP_PORT_DC_DATA, 16'hc3a5);
        cmd(1'b0, UBP_IDX_WIDE_SCRATCH);
        rd(UBP_PORT_HC_DATA, 16'hbeef, "wide low half");
        rd(UBP_PORT_HC_DATA, 16'h1357, "wide high half");
        cmd(1'b1, UBP_IDX_DC_SETUP);
        rd(UBP_PORT_DC_DATA, 16'hc3a5, "device register");
        // Host FIFO burst of half the byte count, written then read back.
        cmd(1'b0, UBP_IDX_HC_FIFO | 8'h80);
        for (int i = 0; i < 3; i++) begin
            wr(UBP_PORT_HC_DATA, 16'h1100 + 16'(i));
        end
        wr(UBP_PORT_HC_DATA, 16'h2222); // Beyond half the count, refused.
        cmd(1'b0, UBP_IDX_HC_FIFO);
        for (int i = 0; i < 3; i++) begin
            rd(UBP_PORT_HC_DATA, 16'h1100 + 16'(i), "fifo word");
        end
        // Channel 1 in burst mode with the internal count: four bytes end after two words.
        cmd(1'b0, UBP_IDX_BYTE_COUNT | 8'h80);
        wr(UBP_PORT_HC_DATA, 16'h0004);
        cmd(1'b0, UBP_IDX_DMA_SETUP | 8'h80);
        wr(UBP_PORT_HC_DATA, 16'h0007);
        cmd(1'b0, UBP_IDX_HC_FIFO | 8'h80);
        wait_req(1'b0, 1'b1, "host request rise");
        chk("device request idle", 16'h0000, {15'h0000, device_side_dma_request});
        // The DMA master takes the bus only once the processor cycle is over.
        dma_go = 1'b1;
        wait_req(1'b0, 1'b0, "host request end");
        wait_idle();
        chk("counted dma words", 16'h0002, {12'h000, p_words});
        cmd(1'b0, UBP_IDX_DMA_SETUP);
        rd(UBP_PORT_HC_DATA, 16'h0006, "dma_setup after end");
        cmd(1'b0, UBP_IDX_HC_FIFO);
        rd(UBP_PORT_HC_DATA, 16'h7700, "dma word 0");
        rd(UBP_PORT_HC_DATA, 16'h7701, "dma word 1");
        // Channel 2 in single-cycle mode, ended from outside after one word.
        cmd(1'b0, UBP_IDX_DMA_SETUP | 8'h80);
        wr(UBP_PORT_HC_DATA, 16'h0001);
        dma_go = 1'b0;
        sel = 1'b1;
        end_after = 4'h1;
        cmd(1'b1, UBP_IDX_DC_FIFO | 8'h80);
        wait_req(1'b1, 1'b1, "device request rise");
        chk("host request idle", 16'h0000, {15'h0000, host_side_dma_request});
        dma_go = 1'b1;
        wait_req(1'b1, 1'b0, "device request end");
        wait_idle();
        chk("external end words", 16'h0001, {12'h000, p_words});
        report_and_stop();
    end
endmodule // test_usb_dual_controller_host_bus_port
`default_nettype wire

/* File: bench/ubp_dma_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Processor-side DMA controller model; it masters write bursts into the FIFO.
module ubp_dma_master_model (
    input wire logic clk,              // System clock.
    input wire logic req,              // Request of the channel being served.
    input wire logic [3:0] end_after,  // Words before raising end; zero means never.
    output logic ack_n,                // Acknowledge, active low.
    output logic wr_n,                 // Write strobe, active low.
    output logic [15:0] data,          // Word offered to the FIFO.
    output logic transfer_end_input,                  // External end of transfer, active high.
    output logic [3:0] words           // Words moved in the last service.
);
    // Serves one request at a time, writing only, so one direction per cycle.
    initial begin
        ack_n = 1'b1;
        wr_n = 1'b1;
        data = 16'h0000;
        transfer_end_input = 1'b0;
        words = 4'h0;
        forever begin
            @(posedge clk);
            #2;
            if (req === 1'b1) begin
                ack_n = 1'b0;
                words = 4'h0;
                while (req === 1'b1 && words < 4'h8) begin
                    wr_n = 1'b0;
                    data = 16'h7700 + {12'h000, words};
                    repeat (8) @(posedge clk);
                    #2;
                    wr_n = 1'b1;
                    data = ~data; // Released bus shows no stale word.
                    words = words + 4'h1;
                    if (words == end_after) begin
                        transfer_end_input = 1'b1;
                    end
                    repeat (8) @(posedge clk);
                    #2;
                end
                ack_n = 1'b1;
                transfer_end_input = 1'b0;
            end
        end
    end
endmodule // ubp_dma_master_model
`default_nettype wire

/* File: src/ubp_host_bus_port.sv */
`timescale 1ns/10ps
`default_nettype none
module ubp_host_bus_port
    import ubp_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int FIFO_WORDS = 64
) (
    input wire logic CLK,                          // 40 MHz clock.
    input wire logic RST_N,                        // Synchronous reset, active low.
    input wire logic CS_N,                         // Chip select, active low.
    input wire logic PORT_KIND_SELECT,             // 1 selects command, 0 data.
    input wire logic CONTROLLER_HALF_SELECT,       // 1 selects device half.
    input wire logic RD_N,                         // Read strobe, active low.
    input wire logic WR_N,                         // Write strobe, active low.
    input wire logic [DATA_W-1:0] DATA_IN,         // Data bus input.
    output logic [DATA_W-1:0] DATA_OUT,            // Data bus output.
    output logic DATA_OE,                          // High while driving data.
    output logic HOST_SIDE_DMA_REQUEST,            // Channel 1 request.
    input wire logic HOST_SIDE_DMA_ACK_N,          // Channel 1 acknowledge.
    output logic DEVICE_SIDE_DMA_REQUEST,          // Channel 2 request.
    input wire logic DEVICE_SIDE_DMA_ACK_N,        // Channel 2 acknowledge.
    input wire logic TRANSFER_END_INPUT            // External end of transfer.
);
    localparam int AW = $clog2(FIFO_WORDS);

    // Refuse widths and depths that the port logic and the wrapping address cannot serve.
    if (DATA_W != 16) begin : g_bad_width
        $error("DATA_W must be 16");
    end
    if (FIFO_WORDS < 2 || FIFO_WORDS > 32768 || (FIFO_WORDS & (FIFO_WORDS - 1)) != 0)
    begin : g_bad_depth
        $error("FIFO_WORDS must be a power of two from 2 to 32768");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and strobe edges
    // ------------------------------------------------------------------
    logic [7:0] pins_raw, pins_s;
    assign pins_raw = {TRANSFER_END_INPUT, DEVICE_SIDE_DMA_ACK_N, HOST_SIDE_DMA_ACK_N,
                       CONTROLLER_HALF_SELECT, PORT_KIND_SELECT, WR_N, RD_N, CS_N};

    // Idle levels after reset: strobes, select and both acknowledges high, end low.
    ubp_sync #(.WIDTH(8), .RST_VAL(8'h7f)) u_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .din(pins_raw),
        .dout(pins_s)
    );

    logic cs_s, rd_s, wr_s, a0_s, a1_s, ack1_s, ack2_s, eot_s;
    assign {eot_s, ack2_s, ack1_s, a1_s, a0_s, wr_s, rd_s, cs_s} = pins_s;

    logic rd_n_q, wr_n_q;
    logic [DATA_W-1:0] din_q;
    logic [1:0] port;
    logic ack_any, rd_start, wr_start, rd_end;
    assign port = {a1_s, a0_s};
    assign ack_any = !ack1_s || !ack2_s;
    // Strobe direction decides read or write; a data-phase write also needs bit 7 of the held command.
    assign rd_start = !rd_s && rd_n_q && (!cs_s || ack_any);
    assign wr_start = !wr_s && wr_n_q && (!cs_s || ack_any);
    assign rd_end = rd_s && !rd_n_q;

    // ------------------------------------------------------------------
    // Command, registers and FIFO state
    // ------------------------------------------------------------------
    logic [7:0] hc_cmd_q, hc_cmd_d, dc_cmd_q, dc_cmd_d;
    logic [15:0] dma_setup_q, dma_setup_d, byte_count_q, byte_count_d;
    logic [31:0] wide_q, wide_d;
    logic [15:0] dc_setup_q, dc_setup_d;
    logic phase_q, phase_d;
    logic [15:0] hc_words_q, hc_words_d, dc_words_q, dc_words_d;
    logic [15:0] dma_bytes_q, dma_bytes_d;
    logic [DATA_W-1:0] hc_mem [FIFO_WORDS];
    logic [DATA_W-1:0] dc_mem [FIFO_WORDS];
    logic [DATA_W-1:0] dout_q, dout_d;
    logic oe_q, oe_d;
    logic req1_q, req1_d, req2_q, req2_d;
    logic burst_open_q, burst_open_d;

    logic dma_on, dma_burst, dma_cnt_en, dma_done;
    assign dma_on = dma_setup_q[UBP_DMA_ENABLE_BIT];
    assign dma_burst = dma_setup_q[UBP_DMA_BURST_BIT];
    assign dma_cnt_en = dma_setup_q[UBP_DMA_COUNT_EN_BIT];
    // Internal end when the counted bytes reach the byte count.
    assign dma_done = dma_cnt_en && (dma_bytes_q >= byte_count_q);

    logic hc_wr, dc_wr, hc_rd, dc_rd;
    logic [7:0] cmd;
    logic is_write;
    logic [6:0] idx;
    assign hc_wr = wr_start && ((!cs_s && port == UBP_PORT_HC_DATA) || !ack1_s);
    assign dc_wr = wr_start && ((!cs_s && port == UBP_PORT_DC_DATA) || !ack2_s);
    assign hc_rd = rd_start && ((!cs_s && port == UBP_PORT_HC_DATA) || !ack1_s);
    assign dc_rd = rd_start && ((!cs_s && port == UBP_PORT_DC_DATA) || !ack2_s);
    // Data phases use the held command of their half.
    assign cmd = (hc_wr || hc_rd) ? hc_cmd_q : dc_cmd_q;
    assign is_write = cmd[UBP_WRITE_BIT];
    assign idx = cmd[6:0];

    logic [AW-1:0] hc_addr, dc_addr;
    assign hc_addr = hc_words_q[AW-1:0];
    assign dc_addr = dc_words_q[AW-1:0];
    logic hc_room, dc_room;
    assign hc_room = hc_words_q < {1'b0, byte_count_q[15:1]};
    assign dc_room = dc_words_q < {1'b0, byte_count_q[15:1]};

    // Next-state logic for command, register, FIFO and DMA state.
    always_comb begin
        hc_cmd_d = hc_cmd_q;
        dc_cmd_d = dc_cmd_q;
        dma_setup_d = dma_setup_q;
        byte_count_d = byte_count_q;
        wide_d = wide_q;
        dc_setup_d = dc_setup_q;
        phase_d = phase_q;
        hc_words_d = hc_words_q;
        dc_words_d = dc_words_q;
        dma_bytes_d = dma_bytes_q;
        dout_d = dout_q;
        oe_d = oe_q && !rd_end;
        req1_d = req1_q;
        req2_d = req2_q;
        burst_open_d = burst_open_q;
        // Command phase: low byte only, upper byte is ignored.
        if (wr_start && !cs_s && port == UBP_PORT_HC_CMD) begin
            hc_cmd_d = din_q[7:0];
            phase_d = 1'b0;
            hc_words_d = '0;
            dma_bytes_d = '0;
        end else if (wr_start && !cs_s && port == UBP_PORT_DC_CMD) begin
            dc_cmd_d = din_q[7:0];
            dc_words_d = '0;
            dma_bytes_d = '0;
        end
        // Register and FIFO writes.
        if (hc_wr && is_write) begin
            unique case ({1'b0, idx})
                UBP_IDX_DMA_SETUP: dma_setup_d = din_q;
                UBP_IDX_BYTE_COUNT: byte_count_d = din_q;
                UBP_IDX_WIDE_SCRATCH: begin
                    // Low half first, then high half.
                    if (!phase_q) wide_d[15:0] = din_q;
                    else wide_d[31:16] = din_q;
                    phase_d = !phase_q;
                end
                UBP_IDX_HC_FIFO: begin
                    // Accept words up to half the byte count.
                    if (hc_words_q < {1'b0, byte_count_q[15:1]}) begin
                        hc_words_d = hc_words_q + 16'h0001;
                    end
                end
                default: ;
            endcase
        end
        if (dc_wr && is_write) begin
            if ({1'b0, idx} == UBP_IDX_DC_SETUP) dc_setup_d = din_q;
            if ({1'b0, idx} == UBP_IDX_DC_FIFO &&
                dc_words_q < {1'b0, byte_count_q[15:1]}) begin
                dc_words_d = dc_words_q + 16'h0001;
            end
        end
        // Reads drive the bus until the strobe rises.
        if (hc_rd) begin
            oe_d = 1'b1;
            unique case ({1'b0, idx})
                UBP_IDX_DMA_SETUP: dout_d = dma_setup_q;
                UBP_IDX_BYTE_COUNT: dout_d = byte_count_q;
                UBP_IDX_CHIP_ID: dout_d = UBP_CHIP_ID_VALUE;
                UBP_IDX_WIDE_SCRATCH: begin
                    dout_d = phase_q ? wide_q[31:16] : wide_q[15:0];
                    phase_d = !phase_q;
                end
                UBP_IDX_HC_FIFO: begin
                    dout_d = hc_mem[hc_addr];
                    if (hc_words_q < {1'b0, byte_count_q[15:1]}) begin
                        hc_words_d = hc_words_q + 16'h0001;
                    end
                end
                default: dout_d = 16'h0000;
            endcase
        end else if (dc_rd) begin
            oe_d = 1'b1;
            if ({1'b0, idx} == UBP_IDX_DC_SETUP) dout_d = dc_setup_q;
            else if ({1'b0, idx} == UBP_IDX_DC_FIFO) begin
                dout_d = dc_mem[dc_addr];
                if (dc_words_q < {1'b0, byte_count_q[15:1]}) begin
                    dc_words_d = dc_words_q + 16'h0001;
                end
            end else dout_d = 16'h0000;
        end
        // DMA: count bytes on acknowledged strobes.
        if ((rd_start || wr_start) && ack_any) begin
            dma_bytes_d = dma_bytes_q + 16'h0002;
            burst_open_d = 1'b1;
            // Single-cycle mode drops the request on each word.
            if (!dma_burst) begin
                req1_d = 1'b0;
                req2_d = 1'b0;
            end
        end
        // Raise a request at each burst start once a FIFO command is held.
        if (dma_on && !burst_open_q && ack1_s && ack2_s) begin
            req1_d = (hc_cmd_q[6:0] == UBP_IDX_HC_FIFO[6:0]);
            req2_d = (dc_cmd_q[6:0] == UBP_IDX_DC_FIFO[6:0]);
        end
        if (ack1_s && ack2_s && burst_open_q) burst_open_d = 1'b0;
        // External or internal end terminates the transfer.
        if (eot_s || dma_done || !dma_on) begin
            req1_d = 1'b0;
            req2_d = 1'b0;
            if (eot_s || dma_done) dma_setup_d[UBP_DMA_ENABLE_BIT] = 1'b0;
        end
    end

    // FIFO memory writes; words past half the byte count are dropped.
    always_ff @(posedge CLK) begin
        if (hc_wr && is_write && {1'b0, idx} == UBP_IDX_HC_FIFO && hc_room) begin
            hc_mem[hc_addr] <= din_q;
        end
        if (dc_wr && is_write && {1'b0, idx} == UBP_IDX_DC_FIFO && dc_room) begin
            dc_mem[dc_addr] <= din_q;
        end
    end

    // State registers.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            din_q <= '0;
            hc_cmd_q <= UBP_CMD_RST;
            dc_cmd_q <= UBP_CMD_RST;
            dma_setup_q <= UBP_DMA_SETUP_RST;
            byte_count_q <= UBP_BYTE_COUNT_RST;
            wide_q <= '0;
            dc_setup_q <= '0;
            phase_q <= 1'b0;
            hc_words_q <= '0;
            dc_words_q <= '0;
            dma_bytes_q <= '0;
            dout_q <= '0;
            oe_q <= 1'b0;
            req1_q <= 1'b0;
            req2_q <= 1'b0;
            burst_open_q <= 1'b0;
        end else begin
            rd_n_q <= rd_s;
            wr_n_q <= wr_s;
            din_q <= DATA_IN;
            hc_cmd_q <= hc_cmd_d;
            dc_cmd_q <= dc_cmd_d;
            dma_setup_q <= dma_setup_d;
            byte_count_q <= byte_count_d;
            wide_q <= wide_d;
            dc_setup_q <= dc_setup_d;
            phase_q <= phase_d;
            hc_words_q <= hc_words_d;
            dc_words_q <= dc_words_d;
            dma_bytes_q <= dma_bytes_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            req1_q <= req1_d;
            req2_q <= req2_d;
            burst_open_q <= burst_open_d;
        end
    end

    assign DATA_OUT = dout_q;
    assign DATA_OE = oe_q;
    assign HOST_SIDE_DMA_REQUEST = req1_q;
    assign DEVICE_SIDE_DMA_REQUEST = req2_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_id_read;
        @(posedge CLK) disable iff (!RST_N)
        (hc_rd && !ack_any && hc_cmd_q == UBP_IDX_CHIP_ID) |=> (DATA_OE && DATA_OUT == UBP_CHIP_ID_VALUE);
    endproperty
    a_id_read: assert property (p_id_read) else $error("identity read wrong");

    property p_cmd_hold;
        @(posedge CLK) disable iff (!RST_N)
        !(wr_start && !cs_s && port == UBP_PORT_HC_CMD) |=> $stable(hc_cmd_q);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command index changed");

    property p_cmd_load;
        @(posedge CLK) disable iff (!RST_N)
        (wr_start && !cs_s && port == UBP_PORT_DC_CMD) |=> dc_cmd_q == $past(din_q[7:0]);
    endproperty
    a_cmd_load: assert property (p_cmd_load) else $error("command not loaded");

    property p_count_write;
        @(posedge CLK) disable iff (!RST_N)
        (hc_wr && hc_cmd_q == (UBP_IDX_BYTE_COUNT | 8'h80)) |=> byte_count_q == $past(din_q);
    endproperty
    a_count_write: assert property (p_count_write) else $error("byte count write lost");

    property p_eot;
        @(posedge CLK) disable iff (!RST_N)
        eot_s |=> !HOST_SIDE_DMA_REQUEST && !DEVICE_SIDE_DMA_REQUEST;
    endproperty
    a_eot: assert property (p_eot) else $error("request survives transfer end");

    property p_internal_end;
        @(posedge CLK) disable iff (!RST_N)
        dma_done |=> !dma_on ##1 !HOST_SIDE_DMA_REQUEST;
    endproperty
    a_internal_end: assert property (p_internal_end) else $error("count end ignored");

    property p_fifo_limit;
        @(posedge CLK) disable iff (!RST_N)
        (hc_wr && is_write && {1'b0, idx} == UBP_IDX_HC_FIFO && !hc_room)
            |=> $stable(hc_words_q);
    endproperty
    a_fifo_limit: assert property (p_fifo_limit) else $error("fifo past half count");

    property p_single_cycle;
        @(posedge CLK) disable iff (!RST_N)
        ((rd_start || wr_start) && ack_any && !dma_burst)
            |=> !HOST_SIDE_DMA_REQUEST && !DEVICE_SIDE_DMA_REQUEST;
    endproperty
    a_single_cycle: assert property (p_single_cycle) else $error("single cycle held request");

    property p_oe_read_only;
        @(posedge CLK) disable iff (!RST_N)
        $rose(DATA_OE) |-> $past(rd_start);
    endproperty
    a_oe_read_only: assert property (p_oe_read_only) else $error("bus driven without read");
endmodule // ubp_host_bus_port
`default_nettype wire

/* File: src/ubp_pkg.sv */
package ubp_pkg;
    // Port select codes on the address pair {controller_half_select, port_kind_select}.
    localparam logic [1:0] UBP_PORT_HC_DATA = 2'h0;
    localparam logic [1:0] UBP_PORT_HC_CMD = 2'h1;
    localparam logic [1:0] UBP_PORT_DC_DATA = 2'h2;
    localparam logic [1:0] UBP_PORT_DC_CMD = 2'h3;
    // Register read indices; the write index has bit 7 set.
    localparam logic [7:0] UBP_IDX_DMA_SETUP = 8'h21;
    localparam logic [7:0] UBP_IDX_BYTE_COUNT = 8'h22;
    localparam logic [7:0] UBP_IDX_CHIP_ID = 8'h27;
    localparam logic [7:0] UBP_IDX_WIDE_SCRATCH = 8'h2c;
    localparam logic [7:0] UBP_IDX_HC_FIFO = 8'h40;
    localparam logic [7:0] UBP_IDX_DC_FIFO = 8'h1c;
    localparam logic [7:0] UBP_IDX_DC_SETUP = 8'h3e;
    localparam int UBP_WRITE_BIT = 7;
    // Fields of dma_setup.
    localparam int UBP_DMA_ENABLE_BIT = 0;
    localparam int UBP_DMA_BURST_BIT = 1;
    localparam int UBP_DMA_COUNT_EN_BIT = 2;
    // Reset values.
    localparam logic [15:0] UBP_DMA_SETUP_RST = 16'h0000;
    localparam logic [15:0] UBP_BYTE_COUNT_RST = 16'h0000;
    localparam logic [15:0] UBP_CHIP_ID_VALUE = 16'h5a01; // Arbitrary value.
    localparam logic [7:0] UBP_CMD_RST = 8'h00;
    // Pin synchroniser depth.
    localparam int UBP_SYNC_STAGES = 3;
endpackage : ubp_pkg

/* File: src/ubp_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree.
module ubp_sync
    import ubp_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic CLK,              // System clock.
    input wire logic RST_N,            // Synchronous reset, active low.
    input wire logic [WIDTH-1:0] din,  // Asynchronous input.
    output logic [WIDTH-1:0] dout      // Filtered, synchronised level.
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
    logic [WIDTH-1:0] out_d;

    // Hold the output where the last two stages disagree.
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
        end
    end

    // Shift chain; only stage two reads stage one.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            out_q <= RST_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule // ubp_sync
`default_nettype wire
